// ===== dicr_pkg.sv
package dicr_pkg;
   localparam int BYTE_W    = 8;
   localparam int WORD_W    = 16;
   localparam int NUM_DAC   = 4;
   localparam int NUM_CURRENT_OUTPUT  = 2;
   localparam int DAC_IDX_W = 2;
   localparam int SYNC_W    = 3;
   localparam int MODE_LO   = 0;
   localparam int MODE_W    = 2;
   localparam int LOAD_W    = 2;
   localparam int BIT_COR   = 7;
   localparam int BIT_EOD   = 6;
   localparam int BIT_DIS   = 5;
   localparam int BIT_SINK  = 4;
   localparam int BIT_RSVD  = 3;
   localparam int BIT_REF   = 2;

   localparam logic [7:0]  ADR_LOW      = 8'hB5;
   localparam logic [7:0]  ADR_HIGH     = 8'hB6;
   localparam logic [7:0]  ADR_SEL      = 8'hB7;
   localparam logic [7:0]  SEL_DAC_LAST = 8'h03;
   localparam logic [7:0]  SEL_CTRL01   = 8'h04;
   localparam logic [7:0]  SEL_CTRL23   = 8'h05;
   localparam logic [7:0]  SEL_LOAD     = 8'h06;
   localparam logic [7:0]  RST_SEL      = 8'h00;
   localparam logic [7:0]  RST_CTRL01   = 8'h63;
   localparam logic [7:0]  RST_CTRL23   = 8'h03;
   localparam logic [7:0]  RST_LOAD     = 8'h00;
   localparam logic [7:0]  RST_BYTE     = 8'h00;
   localparam logic [15:0] RST_WORD     = 16'h0000;
   localparam logic [7:0]  MASK_CTRL01  = 8'h77;
   localparam logic [7:0]  MASK_CTRL23  = 8'h07;

   localparam logic [1:0]  MODE_NORMAL  = 2'h0;
   localparam logic [1:0]  MODE_HIZ     = 2'h3;
   localparam logic [1:0]  LOAD_DIRECT  = 2'h0;
   localparam logic [1:0]  LOAD_MILLISECOND_TICK    = 2'h1;
   localparam logic [1:0]  LOAD_HALF_MILLISECOND_TICK   = 2'h2;
   localparam logic [1:0]  LOAD_SYNC    = 2'h3;
   localparam logic [1:0]  OVR_TICKS    = 2'h3;
   localparam logic [1:0]  CNT_ZERO     = 2'h0;
   localparam logic [1:0]  CNT_STEP     = 2'h1;
endpackage

// ===== dicr_load.sv
module dicr_load (
   input  wire logic                        clk_i,
   input  wire logic                        srst_i,
   input  wire logic                        wr_lo_i,
   input  wire logic                        wr_hi_i,
   input  wire logic [dicr_pkg::BYTE_W-1:0] wdata_i,
   input  wire logic [dicr_pkg::LOAD_W-1:0] opt_i,
   input  wire logic                        millisecond_tick_i,
   input  wire logic                        half_millisecond_tick_i,
   input  wire logic                        sync_i,
   output logic      [dicr_pkg::WORD_W-1:0] hold_o,
   output logic      [dicr_pkg::WORD_W-1:0] drive_o
);
   import dicr_pkg::*;

   typedef struct packed {
      logic [WORD_W-1:0] hold;
      logic [WORD_W-1:0] drive;
   } dicr_load_st_t;

   dicr_load_st_t q;
   dicr_load_st_t d;

   always_comb begin
      d = q;
      if (wr_lo_i) begin
         d.hold[BYTE_W-1:0] = wdata_i;
      end
      if (wr_hi_i) begin
         d.hold[WORD_W-1:BYTE_W] = wdata_i;
      end
      case (opt_i)
         LOAD_DIRECT: begin
            if (wr_lo_i) begin
               d.drive = {q.hold[WORD_W-1:BYTE_W], wdata_i};
            end
         end
         LOAD_MILLISECOND_TICK: begin
            if (millisecond_tick_i) begin
               d.drive = q.hold;
            end
         end
         LOAD_HALF_MILLISECOND_TICK: begin
            if (half_millisecond_tick_i) begin
               d.drive = q.hold;
            end
         end
         default: begin
         end
      endcase
      if (sync_i) begin
         d.drive = q.hold;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         q <= '{hold: RST_WORD, drive: RST_WORD};
      end else begin
         q <= d;
      end
   end

   assign hold_o  = q.hold;
   assign drive_o = q.drive;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   a_direct_load: assert property (
      opt_i == LOAD_DIRECT && wr_lo_i && !sync_i
      |=> q.drive == {$past(q.hold[WORD_W-1:BYTE_W]), $past(wdata_i)})
      else $error("direct load missed the output");
   a_high_only: assert property (
      opt_i == LOAD_DIRECT && wr_hi_i && !sync_i |=> $stable(q.drive))
      else $error("high byte write moved the output");
   a_millisecond_tick_load: assert property (
      opt_i == LOAD_MILLISECOND_TICK && millisecond_tick_i |=> q.drive == $past(q.hold))
      else $error("millisecond load missed");
   a_half_millisecond_tick_load: assert property (
      opt_i == LOAD_HALF_MILLISECOND_TICK && half_millisecond_tick_i |=> q.drive == $past(q.hold))
      else $error("half millisecond load missed");
   a_sync_load: assert property (
      sync_i |=> q.drive == $past(q.hold))
      else $error("sync load missed");
endmodule

// ===== dicr_ovr.sv
module dicr_ovr (
   input  wire logic clk_i,
   input  wire logic srst_i,
   input  wire logic raw_i,
   input  wire logic millisecond_tick_i,
   input  wire logic en_i,
   input  wire logic clr_i,
   output logic      status_o,
   output logic      hiz_o
);
   import dicr_pkg::*;

   typedef struct packed {
      logic [SYNC_W-1:0] sync;
      logic              filt;
      logic [1:0]        cnt;
      logic              latch;
   } dicr_ovr_st_t;

   dicr_ovr_st_t q;
   dicr_ovr_st_t d;

   always_comb begin
      d = q;
      d.sync = {q.sync[SYNC_W-2:0], raw_i};
      if (q.sync[SYNC_W-2] == q.sync[SYNC_W-1]) begin
         d.filt = q.sync[SYNC_W-1];
      end
      if (clr_i && !q.filt) begin
         d.latch = 1'b0;
      end
      if (!en_i) begin
         d.latch = 1'b0;
         d.cnt   = CNT_ZERO;
      end else if (!q.filt) begin
         d.cnt = CNT_ZERO;
      end else if (millisecond_tick_i) begin
         if (q.cnt == OVR_TICKS - CNT_STEP) begin
            d.latch = 1'b1;
         end else begin
            d.cnt = q.cnt + CNT_STEP;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         q <= '{sync: '0, filt: 1'b0, cnt: CNT_ZERO, latch: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign status_o = en_i ? q.latch : q.filt;
   assign hiz_o    = q.latch;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   a_third_tick: assert property (
      en_i && q.filt && q.cnt == OVR_TICKS - CNT_STEP && millisecond_tick_i |=> q.latch)
      else $error("overload not latched on third tick");
   a_latch_cause: assert property (
      $rose(q.latch) |-> $past(millisecond_tick_i) && $past(q.cnt) == OVR_TICKS - CNT_STEP)
      else $error("overload latched early");
   a_clear_ok: assert property (
      clr_i && !q.filt |=> !q.latch)
      else $error("clear did not release output");
   a_clear_held: assert property (
      q.latch && en_i && !(clr_i && !q.filt) |=> q.latch)
      else $error("latch released without a valid clear");
   a_raw_status: assert property (
      !en_i |-> status_o == q.filt ##1 !q.latch)
      else $error("disabled detection shows wrong status");
   c_latched: cover property (en_i && $rose(q.latch));
endmodule

// ===== dicr_top.sv
// Function
// - Selector steers byte ports: 00-03 data, 04/05 controls, 06 load, 07 none.
// - Each DAC data word is 16 bits, low and high bytes, reset zero.
// - Writing 0 to status releases high impedance unless overload persists; 1 ignored.
// - Status reads latched overload when detecting, otherwise the synchronized, filtered over-range signal.
// - Three consecutive millisecond ticks of overload disable output, registers kept.
// - DAC0/1 current output disable bit: 0 on, 1 off; normal mode only.
// - DAC0/1 direction bit selects sourcing at 0, external sinking at 1.
// - Two-bit output mode: 00 normal, others power down; current off unless 00.
// - Load register holds two-bit option per DAC, DAC0 lowest, DAC3 highest.
// - Option 00: low byte write loads buffer and output; high byte only buffers.
// - Option 01: buffered word reaches output on next millisecond tick.
// - Option 10: buffered word reaches output on next half millisecond tick.
// - Writing option 11 transfers buffered word to output right after the write.
module dicr_top (
   input  wire logic                          CLK_I,
   input  wire logic                          SRST_I,
   input  wire logic [dicr_pkg::BYTE_W-1:0]   SFR_ADDR_I,
   input  wire logic [dicr_pkg::BYTE_W-1:0]   SFR_WDATA_I,
   input  wire logic                          SFR_WR_I,
   input  wire logic                          SFR_RD_I,
   output logic      [dicr_pkg::BYTE_W-1:0]   SFR_RDATA_O,
   input  wire logic                          MILLISECOND_TICK_TICK_I,
   input  wire logic                          HALF_MILLISECOND_TICK_TICK_I,
   input  wire logic [dicr_pkg::NUM_CURRENT_OUTPUT-1:0] OVER_RANGE_I,
   output logic      [dicr_pkg::WORD_W-1:0]   DAC_VALUE0_O,
   output logic      [dicr_pkg::WORD_W-1:0]   DAC_VALUE1_O,
   output logic      [dicr_pkg::WORD_W-1:0]   DAC_VALUE2_O,
   output logic      [dicr_pkg::WORD_W-1:0]   DAC_VALUE3_O,
   output logic      [2*dicr_pkg::NUM_DAC-1:0] OUT_MODE_O,
   output logic      [dicr_pkg::NUM_DAC-1:0]  REF_SEL_O,
   output logic      [dicr_pkg::NUM_CURRENT_OUTPUT-1:0] CURRENT_OUTPUT_ON_O,
   output logic      [dicr_pkg::NUM_CURRENT_OUTPUT-1:0] CURRENT_OUTPUT_SINK_O,
   output logic      [dicr_pkg::NUM_CURRENT_OUTPUT-1:0] OVR_HIZ_O
);
   import dicr_pkg::*;

   typedef struct packed {
      logic [BYTE_W-1:0]              sel;
      logic [NUM_DAC-1:0][BYTE_W-1:0] ctrl;
      logic [BYTE_W-1:0]              load;
      logic [BYTE_W-1:0]              rdata;
   } dicr_top_st_t;

   localparam dicr_top_st_t RST_ST = '{
      sel:   RST_SEL,
      ctrl:  {RST_CTRL23, RST_CTRL23, RST_CTRL01, RST_CTRL01},
      load:  RST_LOAD,
      rdata: RST_BYTE
   };

   function automatic logic [BYTE_W-1:0] merge(
      input logic [BYTE_W-1:0] old,
      input logic [BYTE_W-1:0] wd,
      input logic [BYTE_W-1:0] msk
   );
      merge = (old & ~msk) | (wd & msk);
   endfunction

   function automatic logic [BYTE_W-1:0] with_status(
      input logic [BYTE_W-1:0] ctl,
      input logic              st
   );
      with_status          = ctl;
      with_status[BIT_COR] = st;
   endfunction

   dicr_top_st_t         q;
   dicr_top_st_t         d;
   logic                 wr_lo;
   logic                 wr_hi;
   logic                 wr_sel;
   logic [NUM_DAC-1:0]   lo_dac;
   logic [NUM_DAC-1:0]   hi_dac;
   logic [NUM_DAC-1:0]   sync_dac;
   logic [NUM_DAC-1:0]   hiz_all;
   logic [NUM_CURRENT_OUTPUT-1:0]  clr_dac;
   logic [NUM_CURRENT_OUTPUT-1:0]  ovr_stat;
   logic [NUM_CURRENT_OUTPUT-1:0]  ovr_hiz;
   logic [MODE_W-1:0]    eff_mode [NUM_DAC];
   logic [WORD_W-1:0]    hold_w   [NUM_DAC];
   logic [WORD_W-1:0]    drive_w  [NUM_DAC];
   logic [BYTE_W-1:0]    rd_mux;

   // Port decode; the selector register gives the byte ports their meaning.
   assign wr_lo  = SFR_WR_I && (SFR_ADDR_I == ADR_LOW);
   assign wr_hi  = SFR_WR_I && (SFR_ADDR_I == ADR_HIGH);
   assign wr_sel = SFR_WR_I && (SFR_ADDR_I == ADR_SEL);

   always_comb begin
      d       = q;
      d.rdata = RST_BYTE;
      if (wr_sel) begin
         d.sel = SFR_WDATA_I;
      end
      if (wr_lo && q.sel == SEL_CTRL01) begin
         d.ctrl[0] = merge(q.ctrl[0], SFR_WDATA_I, MASK_CTRL01);
      end
      if (wr_hi && q.sel == SEL_CTRL01) begin
         d.ctrl[1] = merge(q.ctrl[1], SFR_WDATA_I, MASK_CTRL01);
      end
      if (wr_lo && q.sel == SEL_CTRL23) begin
         d.ctrl[2] = merge(q.ctrl[2], SFR_WDATA_I, MASK_CTRL23);
      end
      if (wr_hi && q.sel == SEL_CTRL23) begin
         d.ctrl[3] = merge(q.ctrl[3], SFR_WDATA_I, MASK_CTRL23);
      end
      if (wr_lo && q.sel == SEL_LOAD) begin
         d.load = SFR_WDATA_I;
      end
      if (SFR_RD_I) begin
         d.rdata = rd_mux;
      end
   end

   // Read data; anything not decoded answers zero.
   always_comb begin
      rd_mux = RST_BYTE;
      if (SFR_ADDR_I == ADR_SEL) begin
         rd_mux = q.sel;
      end else if (SFR_ADDR_I == ADR_LOW) begin
         if (q.sel <= SEL_DAC_LAST) begin
            rd_mux = hold_w[q.sel[DAC_IDX_W-1:0]][BYTE_W-1:0];
         end else if (q.sel == SEL_CTRL01) begin
            rd_mux = with_status(q.ctrl[0], ovr_stat[0]);
         end else if (q.sel == SEL_CTRL23) begin
            rd_mux = q.ctrl[2];
         end else if (q.sel == SEL_LOAD) begin
            rd_mux = q.load;
         end
      end else if (SFR_ADDR_I == ADR_HIGH) begin
         if (q.sel <= SEL_DAC_LAST) begin
            rd_mux = hold_w[q.sel[DAC_IDX_W-1:0]][WORD_W-1:BYTE_W];
         end else if (q.sel == SEL_CTRL01) begin
            rd_mux = with_status(q.ctrl[1], ovr_stat[1]);
         end else if (q.sel == SEL_CTRL23) begin
            rd_mux = q.ctrl[3];
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         q <= RST_ST;
      end else begin
         q <= d;
      end
   end

   // One data and load channel for every DAC.
   for (genvar i = 0; i < NUM_DAC; i++) begin : g_dac
      assign lo_dac[i]   = wr_lo && (q.sel == BYTE_W'(i));
      assign hi_dac[i]   = wr_hi && (q.sel == BYTE_W'(i));
      assign sync_dac[i] = wr_lo && (q.sel == SEL_LOAD)
                           && (SFR_WDATA_I[LOAD_W*i +: LOAD_W] == LOAD_SYNC);
      dicr_load u_load (
         .clk_i   (CLK_I),
         .srst_i  (SRST_I),
         .wr_lo_i (lo_dac[i]),
         .wr_hi_i (hi_dac[i]),
         .wdata_i (SFR_WDATA_I),
         .opt_i   (q.load[LOAD_W*i +: LOAD_W]),
         .millisecond_tick_i  (MILLISECOND_TICK_TICK_I),
         .half_millisecond_tick_i (HALF_MILLISECOND_TICK_TICK_I),
         .sync_i  (sync_dac[i]),
         .hold_o  (hold_w[i]),
         .drive_o (drive_w[i])
      );
      assign eff_mode[i] = hiz_all[i] ? MODE_HIZ
                                      : q.ctrl[i][MODE_LO +: MODE_W];
      assign OUT_MODE_O[MODE_W*i +: MODE_W] = eff_mode[i];
      assign REF_SEL_O[i] = q.ctrl[i][BIT_REF];
   end

   // Overload watch for the DACs with a current output.
   for (genvar i = 0; i < NUM_CURRENT_OUTPUT; i++) begin : g_ovr
      assign clr_dac[i] = (i == 0 ? wr_lo : wr_hi) && (q.sel == SEL_CTRL01)
                          && !SFR_WDATA_I[BIT_COR];
      dicr_ovr u_ovr (
         .clk_i    (CLK_I),
         .srst_i   (SRST_I),
         .raw_i    (OVER_RANGE_I[i]),
         .millisecond_tick_i   (MILLISECOND_TICK_TICK_I),
         .en_i     (q.ctrl[i][BIT_EOD]),
         .clr_i    (clr_dac[i]),
         .status_o (ovr_stat[i]),
         .hiz_o    (ovr_hiz[i])
      );
      assign CURRENT_OUTPUT_ON_O[i]   = !q.ctrl[i][BIT_DIS] && (eff_mode[i] == MODE_NORMAL);
      assign CURRENT_OUTPUT_SINK_O[i] = q.ctrl[i][BIT_SINK];
   end

   assign hiz_all      = {{(NUM_DAC - NUM_CURRENT_OUTPUT){1'b0}}, ovr_hiz};
   assign OVR_HIZ_O    = ovr_hiz;
   assign SFR_RDATA_O  = q.rdata;
   assign DAC_VALUE0_O = drive_w[0];
   assign DAC_VALUE1_O = drive_w[1];
   assign DAC_VALUE2_O = drive_w[2];
   assign DAC_VALUE3_O = drive_w[3];

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SRST_I);

   a_ctrl_write: assert property (
      wr_lo && q.sel == SEL_CTRL01
      |=> q.ctrl[0] == merge($past(q.ctrl[0]), $past(SFR_WDATA_I), MASK_CTRL01))
      else $error("control zero write not stored");
   a_data_route: assert property (
      wr_hi && q.sel == SEL_DAC_LAST |=> hold_w[3][WORD_W-1:BYTE_W] == $past(SFR_WDATA_I))
      else $error("high byte not routed to DAC3 word");
   a_unmapped_sel: assert property (
      SFR_WR_I && q.sel > SEL_LOAD && SFR_ADDR_I != ADR_SEL
      |=> $stable(q.ctrl) && $stable(q.load) && $stable(hold_w[0]))
      else $error("unassigned selector changed state");
   a_rsvd_read: assert property (
      SFR_RD_I && SFR_ADDR_I == ADR_LOW && q.sel == SEL_CTRL01
      |=> SFR_RDATA_O[BIT_RSVD] == 1'b0)
      else $error("reserved control bit read as one");
   a_status_read: assert property (
      SFR_RD_I && SFR_ADDR_I == ADR_HIGH && q.sel == SEL_CTRL01
      |=> SFR_RDATA_O[BIT_COR] == $past(ovr_stat[1]))
      else $error("status bit read wrong");
   a_hiz_force: assert property (
      ovr_hiz[0] |-> OUT_MODE_O[MODE_W-1:0] == MODE_HIZ && !CURRENT_OUTPUT_ON_O[0])
      else $error("overload did not disable output");
   a_current_output_mode: assert property (
      q.ctrl[1][MODE_LO +: MODE_W] != MODE_NORMAL |-> !CURRENT_OUTPUT_ON_O[1])
      else $error("current output on outside normal mode");
   a_ref_write: assert property (
      wr_lo && q.sel == SEL_CTRL23 |=> REF_SEL_O[2] == $past(SFR_WDATA_I[BIT_REF]))
      else $error("reference select not applied");
   a_load_field: assert property (
      wr_lo && q.sel == SEL_LOAD && SFR_WDATA_I[LOAD_W*3 +: LOAD_W] == LOAD_SYNC
      |=> DAC_VALUE3_O == $past(hold_w[3]))
      else $error("DAC3 load field misplaced");
   c_sync_load: cover property (wr_lo && q.sel == SEL_LOAD && sync_dac[0]);
   c_ovr_hiz:   cover property ($rose(OVR_HIZ_O[0]));
   c_millisecond_tick_load: cover property (q.load[LOAD_W-1:0] == LOAD_MILLISECOND_TICK && MILLISECOND_TICK_TICK_I);
endmodule

// ===== dicr_analog_model.sv
module dicr_analog_model (
   input  wire logic                          clk_i,
   input  wire logic [dicr_pkg::NUM_CURRENT_OUTPUT-1:0] fault_i,
   output logic      [dicr_pkg::NUM_CURRENT_OUTPUT-1:0] over_range_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import dicr_pkg::*;

   // The current sense comparator flags over-range while a load fault sits on the pin.
   // It settles one clock after the fault appears and drops one clock after it clears.
   always_ff @(posedge clk_i) begin
      over_range_o <= fault_i;
   end
endmodule

// ===== tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dicr_pkg::*;

   logic        clk;
   logic        srst;
   logic [7:0]  addr;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic        wr;
   logic        rd;
   logic        millisecond_tick;
   logic        half_millisecond_tick;
   logic [15:0] dv0;
   logic [15:0] dv1;
   logic [15:0] dv2;
   logic [15:0] dv3;
   logic [7:0]  omode;
   logic [3:0]  refsel;
   logic [1:0]  ion;
   logic [1:0]  isink;
   logic [1:0]  ohiz;
   logic [1:0]  orng;
   logic [1:0]  fault;
   int          fails;
   int          compares;
   logic [7:0]  rst_v [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h63, 8'h03, 8'h00, 8'h00};

   dicr_top i_dut (
      .CLK_I        (clk),
      .SRST_I       (srst),
      .SFR_ADDR_I   (addr),
      .SFR_WDATA_I  (wdata),
      .SFR_WR_I     (wr),
      .SFR_RD_I     (rd),
      .SFR_RDATA_O  (rdata),
      .MILLISECOND_TICK_TICK_I  (millisecond_tick),
      .HALF_MILLISECOND_TICK_TICK_I (half_millisecond_tick),
      .OVER_RANGE_I (orng),
      .DAC_VALUE0_O (dv0),
      .DAC_VALUE1_O (dv1),
      .DAC_VALUE2_O (dv2),
      .DAC_VALUE3_O (dv3),
      .OUT_MODE_O   (omode),
      .REF_SEL_O    (refsel),
      .CURRENT_OUTPUT_ON_O    (ion),
      .CURRENT_OUTPUT_SINK_O  (isink),
      .OVR_HIZ_O    (ohiz)
   );

   dicr_analog_model i_model (
      .clk_i        (clk),
      .fault_i      (fault),
      .over_range_o (orng)
   );

   initial clk = 1'b0;
   always #50 clk = ~clk;

   task automatic complete_run;
      if (fails == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk);
      #1;
      wr = 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      #1;
      addr = a;
      rd = 1'b1;
      @(posedge clk);
      #1;
      rd = 1'b0;
      chk(rdata, e);
   endtask

   // Software always points the selector first, then touches the byte port.
   task automatic sw(input logic [7:0] s, input logic [7:0] a, input logic [7:0] d);
      wr_reg(ADR_SEL, s);
      wr_reg(a, d);
   endtask

   task automatic sr(input logic [7:0] s, input logic [7:0] a, input logic [7:0] e);
      wr_reg(ADR_SEL, s);
      rdchk(a, e);
   endtask

   task automatic tick(input bit half);
      @(posedge clk);
      #1;
      if (half) begin
         half_millisecond_tick = 1'b1;
      end else begin
         millisecond_tick = 1'b1;
      end
      @(posedge clk);
      #1;
      millisecond_tick = 1'b0;
      half_millisecond_tick = 1'b0;
   endtask

   function automatic logic [15:0] dval(input int d);
      case (d)
         0: return dv0;
         1: return dv1;
         2: return dv2;
         default: return dv3;
      endcase
   endfunction

   initial begin
      #1_000_000;
      fails++;
      complete_run();
   end

   initial begin
      fails = 0;
      compares = 0;
      srst = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      millisecond_tick = 1'b0;
      half_millisecond_tick = 1'b0;
      fault = 2'b00;
      repeat (10) @(posedge clk);
      #1;
      srst = 1'b0;
      chk(omode, 8'hFF);
      chk(ion, 2'b00);
      chk(refsel, 4'h0);
      chk(dv0 | dv1 | dv2 | dv3, 16'h0000);
      chk(ohiz, 2'b00);
      rdchk(ADR_SEL, 8'h00);
      for (int s = 0; s < 8; s++) begin
         sr(s[7:0], ADR_LOW, rst_v[s]);
         sr(s[7:0], ADR_HIGH, rst_v[s]);
      end
      for (int d = 0; d < 4; d++) begin
         sw(d[7:0], ADR_HIGH, 8'h10 + d[7:0]);
         chk(dval(d), 16'h0000);
         wr_reg(ADR_LOW, 8'hA0 + d[7:0]);
         idle(1);
         chk(dval(d), {8'h10 + d[7:0], 8'hA0 + d[7:0]});
         rdchk(ADR_HIGH, 8'h10 + d[7:0]);
      end
      sw(SEL_CTRL01, ADR_LOW, 8'hFF);
      rdchk(ADR_LOW, 8'h77);
      chk(isink, 2'b01);
      chk(refsel[0], 1'b1);
      wr_reg(ADR_HIGH, 8'h00);
      chk(ion, 2'b10);
      sw(SEL_CTRL23, ADR_LOW, 8'hFF);
      wr_reg(ADR_HIGH, 8'h04);
      rdchk(ADR_LOW, 8'h07);
      chk(refsel, 4'hD);
      chk(omode, 8'h33);
      sw(8'h07, ADR_LOW, 8'h55);
      rdchk(ADR_LOW, 8'h00);
      sw(SEL_LOAD, ADR_HIGH, 8'h55);
      rdchk(ADR_HIGH, 8'h00);
      rdchk(ADR_LOW, 8'h00);
      wr_reg(8'hB8, 8'h55);
      rdchk(8'hB8, 8'h00);
      sr(SEL_CTRL23, ADR_LOW, 8'h07);
      wr_reg(ADR_SEL, SEL_CTRL01);
      for (int m = 0; m < 4; m++) begin
         wr_reg(ADR_HIGH, m[7:0]);
         chk(omode[3:2], m[1:0]);
         chk(ion[1], m == 0);
      end
      wr_reg(ADR_HIGH, 8'h20);
      chk(ion[1], 1'b0);
      wr_reg(ADR_HIGH, 8'h10);
      chk(isink[1], 1'b1);
      chk(ion[1], 1'b1);
      wr_reg(ADR_LOW, 8'h40);
      chk(ion[0], 1'b1);
      fault = 2'b01;
      idle(6);
      tick(0);
      tick(0);
      idle(2);
      chk(ohiz[0], 1'b0);
      tick(0);
      idle(1);
      chk(ohiz[0], 1'b1);
      chk(omode[1:0], 2'b11);
      chk(ion[0], 1'b0);
      rdchk(ADR_LOW, 8'hC0);
      wr_reg(ADR_LOW, 8'h40);
      idle(1);
      chk(ohiz[0], 1'b1);
      fault = 2'b00;
      idle(6);
      wr_reg(ADR_LOW, 8'hC0);
      idle(1);
      chk(ohiz[0], 1'b1);
      wr_reg(ADR_LOW, 8'h40);
      idle(1);
      chk(ohiz[0], 1'b0);
      rdchk(ADR_LOW, 8'h40);
      chk(dv0, 16'h10A0);
      wr_reg(ADR_LOW, 8'h00);
      fault = 2'b01;
      idle(6);
      rdchk(ADR_LOW, 8'h80);
      tick(0);
      tick(0);
      tick(0);
      idle(1);
      chk(ohiz[0], 1'b0);
      fault = 2'b00;
      idle(6);
      rdchk(ADR_LOW, 8'h00);
      wr_reg(ADR_HIGH, 8'h40);
      fault = 2'b10;
      idle(6);
      tick(0);
      tick(0);
      tick(0);
      idle(1);
      chk(ohiz, 2'b10);
      chk(omode[3:2], 2'b11);
      chk(ion[1], 1'b0);
      rdchk(ADR_HIGH, 8'hC0);
      wr_reg(ADR_HIGH, 8'h00);
      idle(1);
      chk(ohiz[1], 1'b0);
      rdchk(ADR_HIGH, 8'h80);
      fault = 2'b00;
      idle(6);
      sw(8'h02, ADR_HIGH, 8'h5C);
      chk(dv2, 16'h12A2);
      sw(SEL_LOAD, ADR_LOW, 8'h39);
      idle(1);
      chk(dv2, 16'h5CA2);
      rdchk(ADR_LOW, 8'h39);
      sw(8'h00, ADR_HIGH, 8'h77);
      wr_reg(ADR_LOW, 8'h88);
      sw(8'h01, ADR_HIGH, 8'h66);
      wr_reg(ADR_LOW, 8'h99);
      idle(1);
      chk(dv0, 16'h10A0);
      chk(dv1, 16'h11A1);
      tick(1);
      idle(1);
      chk(dv1, 16'h6699);
      chk(dv0, 16'h10A0);
      tick(0);
      idle(1);
      chk(dv0, 16'h7788);
      sw(8'h03, ADR_LOW, 8'h01);
      idle(1);
      chk(dv3, 16'h1301);
      wr_reg(ADR_HIGH, 8'h4E);
      chk(dv3, 16'h1301);
      sw(SEL_LOAD, ADR_LOW, 8'hFB);
      chk(dv3, 16'h4E01);
      chk(dv0, 16'h7788);
      chk(dv2, 16'h5CA2);
      srst = 1'b1;
      idle(2);
      srst = 1'b0;
      chk(dv0 | dv3, 16'h0000);
      chk(omode, 8'hFF);
      sr(SEL_LOAD, ADR_LOW, 8'h00);
      sr(SEL_CTRL01, ADR_HIGH, 8'h63);
      complete_run();
   end
endmodule
